// >>> bench/utx_properties.sv
// assertion checker for the uart transmit block, bound to its top
`timescale 1ns/1ps
`default_nettype none
`include "utx_defs.vh"
module utx_properties
(
   input wire logic CLK, // bus clock
   input wire logic SYS_RST, // sync reset
   input wire logic PSEL, // apb select
   input wire logic PENABLE, // apb access
   input wire logic PWRITE, // apb write
   input wire logic [7:0] PADDR, // apb address
   input wire logic PREADY, // apb ready
   input wire logic PSLVERR, // apb error
   input wire logic TXD, // serial out
   input wire logic TXD_OE, // pin owned
   input wire logic TX_IRQ_REQ, // tx irq
   input wire logic TX_DMA_REQ, // tx dma
   input wire logic RX_IRQ_REQ, // rx irq
   input wire logic RX_DMA_REQ // rx dma
);
   // ====
   // one clock domain, so one default clocking
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (SYS_RST);
   // data register write in its access cycle
   wire dwr = PSEL && PENABLE && PWRITE && PADDR == `UTX_OFF_DATA;
   property p_ready;
      PSEL && !PENABLE |=> PREADY;
   endproperty
   a_ready: assert property (p_ready) else $error("no ready after setup");
   property p_ready_cause;
      PREADY |-> $past(PSEL && !PENABLE);
   endproperty
   a_ready_cause: assert property (p_ready_cause) else $error("ready without setup");
   property p_err;
      PSLVERR |-> PREADY;
   endproperty
   a_err: assert property (p_err) else $error("error outside ready");
   property p_tx_one;
      !(TX_IRQ_REQ && TX_DMA_REQ);
   endproperty
   a_tx_one: assert property (p_tx_one) else $error("tx irq and dma both");
   property p_rx_one;
      !(RX_IRQ_REQ && RX_DMA_REQ);
   endproperty
   a_rx_one: assert property (p_rx_one) else $error("rx irq and dma both");
   property p_rst;
      $fell(SYS_RST) |-> TXD && !TXD_OE && !TX_DMA_REQ && !TX_IRQ_REQ;
   endproperty
   a_rst: assert property (p_rst) else $error("bad state after reset");
   // without bus traffic the dma request cannot drop
   property p_dma_hold;
      TX_DMA_REQ && !PSEL && !$past(PSEL) |=> TX_DMA_REQ;
   endproperty
   a_dma_hold: assert property (p_dma_hold) else $error("dma dropped alone");
   property p_dma_drop;
      dwr && PREADY && !TXD_OE && TX_DMA_REQ |=> ##1 !TX_DMA_REQ;
   endproperty
   a_dma_drop: assert property (p_dma_drop) else $error("dma held after write");
   c_dma: cover property (TX_DMA_REQ);
   c_rx: cover property (RX_IRQ_REQ);
   c_err: cover property (PSLVERR);
endmodule
bind utx_top utx_properties u_props (.CLK, .SYS_RST, .PSEL, .PENABLE, .PWRITE, .PADDR,
   .PREADY, .PSLVERR, .TXD, .TXD_OE, .TX_IRQ_REQ, .TX_DMA_REQ, .RX_IRQ_REQ, .RX_DMA_REQ);
`default_nettype wire

// >>> bench/utx_remote.sv
// remote serial device driving the receive line
`timescale 1ns/1ps
`default_nettype none
module utx_remote
(
   input wire logic CLK, // bus clock
   output logic RXD // line into the block
);
   // ====
   // line idles high between frames
   initial RXD = 1'b1;
   // lsb first, one stop bit; bt is the bit time in clocks
   task automatic send(input logic [7:0] b, input int bt);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++)
      begin
         RXD <= f[i];
         repeat (bt) @(posedge CLK);
      end
   endtask
endmodule
`default_nettype wire

// >>> bench/utx_top_tb_top.sv
// self-checking bench for the uart transmit block
`timescale 1ns/1ps
`default_nettype none
`include "utx_defs.vh"
module utx_top_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err, rxd, txd, txd_oe, tx_irq, tx_dma, tc_irq, rx_irq, rx_dma;
   logic [11:0] s;
   int failures = 0;
   int n_tests = 0;
   int cyc = 0;
   int n;
   int lens[8] = '{10, 11, 11, 12, 13, 14, 14, 15};
   utx_top dut (.CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
      .RXD(rxd), .TXD(txd), .TXD_OE(txd_oe), .TX_IRQ_REQ(tx_irq), .TX_DMA_REQ(tx_dma),
      .TC_IRQ_REQ(tc_irq), .RX_IRQ_REQ(rx_irq), .RX_DMA_REQ(rx_dma));
   utx_remote u_rem (.CLK(clk), .RXD(rxd));
   initial forever #4 clk = ~clk;
   // ====
   task automatic stop_test;
      $display("checks %0d failures %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // hang guard, well above the run length
   always @(posedge clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 30000)
      begin
         failures++;
         stop_test;
      end
   end
   // leading edge wait keeps psel from two writes in one step
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
         @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // sample nb bits from the start bit, mid bit at 16 clocks a bit
   task automatic frame(input int nb);
      s = '0;
      while (txd !== 1'b0)
         @(posedge clk);
      repeat (8) @(posedge clk);
      for (int i = 0; i < nb; i++)
      begin
         s[i] = txd;
         repeat (16) @(posedge clk);
      end
   endtask
   // ====
   initial
   begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      chk({txd, txd_oe}, 2'b10);
      apb(0, `UTX_OFF_DMAS, 0);
      chk(rd, 0);
      apb(1, `UTX_OFF_DMAS, 32'hFF);
      apb(0, `UTX_OFF_DMAS, 0);
      chk(rd, 32'hA0);
      apb(0, 8'h40, 0);
      chk(err, 1);
      apb(0, `UTX_OFF_STAT, 0);
      chk(rd[2:0], 3'h3);
      // routing of the empty flag, transmitter off
      for (int k = 0; k < 4; k++)
      begin
         apb(1, `UTX_OFF_DMAS, {k[1], 7'h0});
         apb(1, `UTX_OFF_CTRL, {k[0], 2'b0});
         repeat (2) @(posedge clk);
         chk({tx_irq, tx_dma}, {k[0] & !k[1], k[0] & k[1]});
      end
      repeat (5) @(posedge clk);
      chk(tx_dma, 1);
      apb(0, `UTX_OFF_STAT, 0);
      apb(1, `UTX_OFF_DATA, 32'h0A5);
      repeat (2) @(posedge clk);
      chk(tx_dma, 0);
      apb(1, `UTX_OFF_DMAS, 0);
      apb(1, `UTX_OFF_BAUD, 1);
      // enabling queues an idle frame ahead of the waiting byte
      apb(1, `UTX_OFF_CTRL, 1);
      n = cyc;
      frame(10);
      n = cyc - n;
      chk(n >= 328 && n <= 348, 1);
      chk(s[9:0], {1'b1, 8'hA5, 1'b0});
      repeat (16) @(posedge clk);
      apb(0, `UTX_OFF_STAT, 0);
      chk({rd[1:0], txd}, 3'h7);
      apb(1, `UTX_OFF_CTRL, 32'h11);
      repeat (2) @(posedge clk);
      chk(tc_irq, 1);
      apb(1, `UTX_OFF_CTRL, 32'hC1);
      apb(0, `UTX_OFF_STAT, 0);
      apb(1, `UTX_OFF_DATA, 32'h0AA);
      frame(12);
      chk(s, {2'b11, 9'h0AA, 1'b0});
      // every break length setting
      for (int m = 0; m < 8; m++)
      begin
         apb(1, `UTX_OFF_CTRL, {m[2], m[0], m[1], 6'h03});
         apb(1, `UTX_OFF_CTRL, {m[2], m[0], m[1], 6'h01});
         while (txd !== 1'b0)
            @(posedge clk);
         n = 0;
         while (txd === 1'b0)
         begin
            n++;
            @(posedge clk);
         end
         chk(n, 16 * lens[m]);
      end
      // break held high at load re-queues: three 10-bit breaks back to back
      apb(1, `UTX_OFF_CTRL, 32'h03);
      apb(1, `UTX_OFF_CTRL, 32'h01);
      while (txd !== 1'b0)
         @(posedge clk);
      n = cyc;
      apb(1, `UTX_OFF_CTRL, 32'h03);
      apb(1, `UTX_OFF_CTRL, 32'h01);
      apb(1, `UTX_OFF_CTRL, 32'h03);
      repeat (200) @(posedge clk);
      apb(1, `UTX_OFF_CTRL, 32'h01);
      while (txd === 1'b0)
         @(posedge clk);
      chk(cyc - n, 16 * 30);
      // disable in mid frame keeps the pin until the stop bit
      apb(1, `UTX_OFF_CTRL, 1);
      apb(0, `UTX_OFF_STAT, 0);
      apb(1, `UTX_OFF_DATA, 32'h055);
      while (txd !== 1'b0)
         @(posedge clk);
      apb(1, `UTX_OFF_CTRL, 0);
      repeat (100) @(posedge clk);
      chk(txd_oe, 1);
      repeat (100) @(posedge clk);
      chk(txd_oe, 0);
      apb(1, `UTX_OFF_CTRL, 32'h20);
      repeat (2) @(posedge clk);
      chk(txd, 0);
      apb(1, `UTX_OFF_CTRL, 0);
      // receive on the shared baud rate, then route the full flag
      @(posedge clk);
      u_rem.send(8'h3C, 16);
      repeat (20) @(posedge clk);
      chk({rx_irq, rx_dma}, 0);
      apb(1, `UTX_OFF_CTRL, 32'h08);
      repeat (2) @(posedge clk);
      chk({rx_irq, rx_dma}, 2'b10);
      apb(1, `UTX_OFF_DMAS, 32'h20);
      repeat (2) @(posedge clk);
      chk({rx_irq, rx_dma}, 2'b01);
      apb(0, `UTX_OFF_DATA, 0);
      chk(rd[8:0], 9'h03C);
      repeat (2) @(posedge clk);
      chk({rx_irq, rx_dma}, 0);
      stop_test;
   end
endmodule
`default_nettype wire

// >>> hw/utx_baud.v
// shared baud generator: 16x oversample tick and bit tick from the bus clock
`timescale 1ns/1ps
`default_nettype none
`include "utx_defs.vh"
module utx_baud
(
   input wire clk, // bus clock
   input wire rst, // synchronous reset
   input wire [12:0] div, // oversample divisor, zero halts
   output reg os_tick, // one pulse per oversample period
   output reg bit_tick // one pulse per bit time
);
reg [12:0] cnt_reg;
reg [3:0] os_cnt_reg;
// ==========================================================
// divider chain; both directions use these same ticks
always @(posedge clk)
begin
   if (rst)
   begin
      cnt_reg <= 13'h0000;
      os_cnt_reg <= 4'h0;
      os_tick <= 1'b0;
      bit_tick <= 1'b0;
   end
   else
   begin
      os_tick <= 1'b0;
      bit_tick <= 1'b0;
      if (div == 13'h0000)
         cnt_reg <= 13'h0000; // halted: no ticks at all
      else if (cnt_reg + 13'h0001 >= div)
      begin
         cnt_reg <= 13'h0000;
         os_tick <= 1'b1;
         os_cnt_reg <= os_cnt_reg + 4'h1;
         bit_tick <= (os_cnt_reg == `UTX_OS_LAST);
      end
      else
         cnt_reg <= cnt_reg + 13'h0001;
   end
end
endmodule
`default_nettype wire

// >>> hw/utx_defs.vh
// register map, field positions, reset values and frame lengths for the uart transmit block
`ifndef UTX_DEFS_VH
`define UTX_DEFS_VH
// ==========================================================
// register offsets (byte addresses)
`define UTX_OFF_CTRL 8'h00
`define UTX_OFF_BAUD 8'h04
`define UTX_OFF_STAT 8'h08
`define UTX_OFF_DATA 8'h0C
`define UTX_OFF_DMAS 8'h10
// ==========================================================
// control register fields
`define UTX_C_TXEN 0
`define UTX_C_BRK 1
`define UTX_C_TXIE 2
`define UTX_C_RXIE 3
`define UTX_C_DONEIE 4
`define UTX_C_INV 5
`define UTX_C_NINE 6
`define UTX_C_TWO 7
`define UTX_C_LONG 8
// dma select register fields
`define UTX_D_TXDMA 7
`define UTX_D_RXDMA 5
`define UTX_DMAS_MASK 8'hA0
// status register fields
`define UTX_S_TXEMPTY 0
`define UTX_S_TC 1
`define UTX_S_RXFULL 2
`define UTX_S_TBUSY 3
`define UTX_S_RBUSY 4
// ==========================================================
// reset values
`define UTX_RST_CTRL 9'h000
`define UTX_RST_DMAS 8'h00
`define UTX_RST_BAUD 13'h0004
// ==========================================================
// frame timing, in bit times and oversample phases
`define UTX_FRAME_BASE 4'hA
`define UTX_OS_LAST 4'hF
`define UTX_OS_MID 4'h7
`endif

// >>> hw/utx_rx.v
// minimal receive framer: resynchronises on every falling edge, samples mid bit
`timescale 1ns/1ps
`default_nettype none
`include "utx_defs.vh"
module utx_rx
(
   input wire clk, // bus clock
   input wire rst, // synchronous reset
   input wire os_tick, // 16x oversample tick
   input wire nine, // nine data bits
   input wire rxd_pin, // asynchronous serial input
   output reg done, // one-cycle pulse, character complete
   output reg [8:0] data, // received character
   output reg active // frame in progress
);
reg s1_reg, s2_reg, s3_reg;
reg [3:0] phase_reg;
reg [3:0] idx_reg;
reg [8:0] sh_reg;
wire fall;
wire [3:0] nbits;
// ==========================================================
// two-flop synchroniser; s3 is the line one oversample ago
always @(posedge clk)
begin
   if (rst)
   begin
      s1_reg <= 1'b1;
      s2_reg <= 1'b1;
      s3_reg <= 1'b1;
   end
   else
   begin
      s1_reg <= rxd_pin;
      s2_reg <= s1_reg;
      if (os_tick)
         s3_reg <= s2_reg;
   end
end
assign fall = os_tick & s3_reg & ~s2_reg;
assign nbits = nine ? 4'h9 : 4'h8;
// ==========================================================
// framer; any falling edge restarts the bit phase
always @(posedge clk)
begin
   if (rst)
   begin
      phase_reg <= 4'h0;
      idx_reg <= 4'h0;
      sh_reg <= 9'h000;
      active <= 1'b0;
      done <= 1'b0;
      data <= 9'h000;
   end
   else
   begin
      done <= 1'b0;
      if (fall)
      begin
         phase_reg <= 4'h0;
         if (!active)
         begin
            active <= 1'b1;
            idx_reg <= 4'h0;
         end
      end
      else if (os_tick && active)
      begin
         phase_reg <= phase_reg + 4'h1;
         if (phase_reg == `UTX_OS_MID)
         begin
            idx_reg <= idx_reg + 4'h1;
            if (idx_reg == 4'h0)
               active <= ~s2_reg; // false start bit drops the frame
            else if (idx_reg <= nbits)
               sh_reg <= {s2_reg, sh_reg[8:1]};
            else
            begin
               active <= 1'b0;
               done <= 1'b1;
               data <= nine ? sh_reg : {1'b0, sh_reg[8:1]};
            end
         end
      end
   end
end
endmodule
`default_nettype wire

// >>> hw/utx_top.v
// uart transmitter with break/idle queueing, dma/interrupt request routing and apb registers
//
// Contract
// - tx empty enable and buffer empty raise dma request if dma select, else irq.
// - tx empty enable clear keeps both tx empty requests low.
// - rx full enable and buffer full raise dma request if dma select, else irq.
// - rx full enable clear keeps both rx full requests low.
// - dma select register reserved bits ignore writes, read zero, reset to zero.
// - tx and rx run independently on one shared baud generator.
// - receive timing realigns on every falling edge of the serial input.
// - output idles high after reset; invert bit reverses every level.
// - enabling transmitter queues one idle preamble frame, then waits for data.
// - shifter is 10, 11 or 12 bits by nine-bit and two-stop settings.
// - free shifter takes buffer on baud tick and sets buffer empty flag.
// - nothing waiting after stop bit sets done flag and idles high.
// - disabling transmitter keeps the pin until current and queued frames finish.
// - break is a frame of zeros; writing break 1 then 0 queues one.
// - break request still set when break loads queues another break.
// - enable written 0 then 1 queues one idle frame of ones.
// - break length 10/11/11/12/13/14 bits for long,nine,two 000..101.
// - break length 14 for 110 and 15 for 111.
//
// Added by the designer: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "utx_defs.vh"
module utx_top
(
   input wire CLK, // 125 MHz bus clock
   input wire SYS_RST, // synchronous reset, active high
   input wire PSEL, // apb select
   input wire PENABLE, // apb access phase
   input wire PWRITE, // apb direction, high for write
   input wire [7:0] PADDR, // apb byte address
   input wire [31:0] PWDATA, // apb write data
   output reg [31:0] PRDATA, // apb read data
   output reg PREADY, // apb ready
   output reg PSLVERR, // apb error, unmapped address
   input wire RXD, // serial input pin
   output reg TXD, // serial output level
   output reg TXD_OE, // high while the transmitter owns the pin
   output reg TX_IRQ_REQ, // tx buffer empty interrupt request
   output reg TX_DMA_REQ, // tx buffer empty dma request
   output reg TC_IRQ_REQ, // transmit complete interrupt request
   output reg RX_IRQ_REQ, // rx buffer full interrupt request
   output reg RX_DMA_REQ // rx buffer full dma request
);
// ==========================================================
// break length by long-break, nine-bit and two-stop settings
function [3:0] brk_len;
   input [2:0] sel;
   begin
      case (sel)
         3'h0: brk_len = 4'hA;
         3'h1: brk_len = 4'hB;
         3'h2: brk_len = 4'hB;
         3'h3: brk_len = 4'hC;
         3'h4: brk_len = 4'hD;
         3'h5: brk_len = 4'hE;
         3'h6: brk_len = 4'hE;
         3'h7: brk_len = 4'hF;
         default: brk_len = 4'hA;
      endcase
   end
endfunction
// ==========================================================
// register state
reg [8:0] ctrl_reg;
reg [7:0] dmas_reg;
reg [12:0] baud_reg;
reg [8:0] txbuf_reg;
reg tx_empty_reg, tc_reg, rx_full_reg;
reg [8:0] rxbuf_reg;
// transmitter state
localparam ST_IDLE = 2'h0;
localparam ST_DATA = 2'h1;
localparam ST_BRK = 2'h2;
localparam ST_PRE = 2'h3;
reg [1:0] st_reg;
reg [11:0] sh_reg;
reg [3:0] cnt_reg;
reg brk_q_reg, idle_q_reg;
wire os_tick, bit_tick;
wire rx_done, rx_active;
wire [8:0] rx_data;
wire tx_en, brk, nine, two, inv;
wire [3:0] frame_len;
wire acc, wr, rd, setup;
wire wr_ctrl, wr_data, rd_data;
wire free;
wire tx_req, rx_req;
reg [31:0] rd_mux;
reg rd_ok;
assign tx_en = ctrl_reg[`UTX_C_TXEN];
assign brk = ctrl_reg[`UTX_C_BRK];
assign nine = ctrl_reg[`UTX_C_NINE];
assign two = ctrl_reg[`UTX_C_TWO];
assign inv = ctrl_reg[`UTX_C_INV];
// frame is start + 8 or 9 data + 1 or 2 stop
assign frame_len = `UTX_FRAME_BASE + {3'h0, nine} + {3'h0, two};
// ==========================================================
// shared baud generator and receive framer
utx_baud u_baud
(
   .clk(CLK),
   .rst(SYS_RST),
   .div(baud_reg),
   .os_tick(os_tick),
   .bit_tick(bit_tick)
);
utx_rx u_rx
(
   .clk(CLK),
   .rst(SYS_RST),
   .os_tick(os_tick),
   .nine(nine),
   .rxd_pin(RXD),
   .done(rx_done),
   .data(rx_data),
   .active(rx_active)
);
// ==========================================================
// apb decode: answer in the first access cycle, no wait states
assign setup = PSEL & ~PENABLE;
assign acc = PSEL & PENABLE & PREADY;
assign wr = acc & PWRITE;
assign rd = acc & ~PWRITE;
assign wr_ctrl = wr & (PADDR == `UTX_OFF_CTRL);
assign wr_data = wr & (PADDR == `UTX_OFF_DATA);
assign rd_data = rd & (PADDR == `UTX_OFF_DATA);
// read mux; unmapped addresses read zero and flag an error
always @*
begin
   rd_mux = 32'h00000000;
   rd_ok = 1'b1;
   case (PADDR)
      `UTX_OFF_CTRL: rd_mux = {23'h0, ctrl_reg};
      `UTX_OFF_BAUD: rd_mux = {19'h0, baud_reg};
      `UTX_OFF_STAT: rd_mux = {27'h0, rx_active, (st_reg != ST_IDLE), rx_full_reg,
         tc_reg, tx_empty_reg};
      `UTX_OFF_DATA: rd_mux = {23'h0, rxbuf_reg};
      `UTX_OFF_DMAS: rd_mux = {24'h000000, dmas_reg};
      default: rd_ok = 1'b0;
   endcase
end
always @(posedge CLK)
begin
   if (SYS_RST)
   begin
      PREADY <= 1'b0;
      PRDATA <= 32'h00000000;
      PSLVERR <= 1'b0;
   end
   else
   begin
      PREADY <= setup;
      PSLVERR <= setup & ~rd_ok;
      if (setup && !PWRITE)
         PRDATA <= rd_mux;
   end
end
// ==========================================================
// software registers
always @(posedge CLK)
begin
   if (SYS_RST)
   begin
      ctrl_reg <= `UTX_RST_CTRL;
      dmas_reg <= `UTX_RST_DMAS;
      baud_reg <= `UTX_RST_BAUD;
      txbuf_reg <= 9'h000;
   end
   else
   begin
      if (wr_ctrl)
         ctrl_reg <= PWDATA[8:0];
      if (wr && PADDR == `UTX_OFF_BAUD)
         baud_reg <= PWDATA[12:0];
      if (wr && PADDR == `UTX_OFF_DMAS)
         dmas_reg <= PWDATA[7:0] & `UTX_DMAS_MASK;
      if (wr_data)
         txbuf_reg <= PWDATA[8:0];
   end
end
// ==========================================================
// status flags; a hardware set wins over a clear in the same cycle
always @(posedge CLK)
begin
   if (SYS_RST)
   begin
      rx_full_reg <= 1'b0;
      rxbuf_reg <= 9'h000;
   end
   else if (rx_done)
   begin
      rx_full_reg <= 1'b1;
      rxbuf_reg <= rx_data;
   end
   else if (rd_data)
      rx_full_reg <= 1'b0;
end
// ==========================================================
// transmit shifter; the next frame loads at the tick the last bit ends
assign free = bit_tick & ((st_reg == ST_IDLE) | (cnt_reg == 4'h1));
always @(posedge CLK)
begin
   if (SYS_RST)
   begin
      st_reg <= ST_IDLE;
      sh_reg <= 12'hFFF;
      cnt_reg <= 4'h0;
      brk_q_reg <= 1'b0;
      idle_q_reg <= 1'b0;
      tx_empty_reg <= 1'b1;
      tc_reg <= 1'b1;
   end
   else
   begin
      // queue requests from control writes
      if (wr_ctrl && brk && !PWDATA[`UTX_C_BRK])
         brk_q_reg <= 1'b1;
      if (wr_ctrl && !tx_en && PWDATA[`UTX_C_TXEN])
      begin
         idle_q_reg <= 1'b1;
         tc_reg <= 1'b0;
      end
      if (wr_data)
      begin
         tx_empty_reg <= 1'b0;
         tc_reg <= 1'b0;
      end
      if (free)
      begin
         // queued frames run even with enable clear so the pin is kept
         if (brk_q_reg)
         begin
            st_reg <= ST_BRK;
            sh_reg <= 12'h000;
            cnt_reg <= brk_len({ctrl_reg[`UTX_C_LONG], nine, two});
            brk_q_reg <= brk;
         end
         else if (idle_q_reg)
         begin
            st_reg <= ST_PRE;
            sh_reg <= 12'hFFF;
            cnt_reg <= frame_len;
            idle_q_reg <= 1'b0;
         end
         else if (tx_en && !tx_empty_reg)
         begin
            st_reg <= ST_DATA;
            sh_reg <= nine ? {2'h3, txbuf_reg, 1'b0} : {3'h7, txbuf_reg[7:0], 1'b0};
            cnt_reg <= frame_len;
            tx_empty_reg <= 1'b1;
         end
         else
         begin
            if (st_reg != ST_IDLE)
               tc_reg <= 1'b1;
            st_reg <= ST_IDLE;
            sh_reg <= 12'hFFF;
            cnt_reg <= 4'h0;
         end
      end
      else if (bit_tick && st_reg != ST_IDLE)
      begin
         // a break refills with zeros, as it may outlast the 12-bit shifter
         sh_reg <= {(st_reg != ST_BRK), sh_reg[11:1]};
         cnt_reg <= cnt_reg - 4'h1;
      end
   end
end
// ==========================================================
// pin and request outputs, all registered
assign tx_req = ctrl_reg[`UTX_C_TXIE] & tx_empty_reg;
assign rx_req = ctrl_reg[`UTX_C_RXIE] & rx_full_reg;
always @(posedge CLK)
begin
   if (SYS_RST)
   begin
      TXD <= 1'b1;
      TXD_OE <= 1'b0;
      TX_IRQ_REQ <= 1'b0;
      TX_DMA_REQ <= 1'b0;
      TC_IRQ_REQ <= 1'b0;
      RX_IRQ_REQ <= 1'b0;
      RX_DMA_REQ <= 1'b0;
   end
   else
   begin
      // idle level is high before inversion
      TXD <= ((st_reg == ST_IDLE) ? 1'b1 : sh_reg[0]) ^ inv;
      // pin held while anything is running or queued
      TXD_OE <= tx_en | (st_reg != ST_IDLE) | brk_q_reg | idle_q_reg;
      TX_DMA_REQ <= tx_req & dmas_reg[`UTX_D_TXDMA];
      TX_IRQ_REQ <= tx_req & ~dmas_reg[`UTX_D_TXDMA];
      // done irq is the caller's to keep off in dma mode
      TC_IRQ_REQ <= ctrl_reg[`UTX_C_DONEIE] & tc_reg;
      RX_DMA_REQ <= rx_req & dmas_reg[`UTX_D_RXDMA];
      RX_IRQ_REQ <= rx_req & ~dmas_reg[`UTX_D_RXDMA];
   end
end
endmodule
`default_nettype wire
